/* File: hdl/sxtc_top.v */
// The AHB-Lite register port and the register addresses were decided locally.
`timescale 1ns/1ps
`include "sxtc_consts.vh"
module sxtc_top #(
   parameter BAUD_W = 8
) (
   input  wire        hclk,
   input  wire        hresetn,
   input  wire        ce,
   input  wire        hsel,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output reg  [31:0] hrdata,
   output reg         hreadyout,
   output reg         hresp,
   input  wire        ck_i,
   output reg         ck_o,
   output reg         ck_oe,
   output reg         dat_o,
   output reg         dat_oe
);
   // ****************************************************************
   // Registers and mode decode
   // ****************************************************************
   reg [7:0]            stat_r;
   reg                  port_on_r;
   reg [BAUD_W-1:0]     baud_r;
   reg                  dp_wr_r;
   reg [`SXTC_AW-1:0]   dp_addr_r;
   reg                  ck_s1_r;
   reg                  ck_s2_r;
   reg                  ck_s3_r;
   reg [10:0]           sh_r;
   reg [3:0]            bits_r;
   reg [6:0]            tcnt_r;
   reg                  empty_r;
   reg                  rose_r;
   wire                 tick;

   wire sync_m  = stat_r[`SXTC_B_SYNC];
   wire master  = sync_m & stat_r[`SXTC_B_CLK_SRC];
   wire nine    = stat_r[`SXTC_B_NINE];
   wire go      = port_on_r & stat_r[`SXTC_B_TRANSMIT_ENABLE_BIT];
   wire ap      = hsel & htrans[1] & hready;
   wire ck_rise = ck_s2_r & ~ck_s3_r;
   wire ck_fall = ~ck_s2_r & ck_s3_r;
   wire load    = dp_wr_r & (dp_addr_r == `SXTC_OFF_DATA) & go & empty_r;

   // Synchronous mode ignores the high-rate bit and uses a fixed tick count.
   wire [6:0] per_bit = sync_m ? `SXTC_TICKS_SYNC :
                        (stat_r[`SXTC_B_HIRATE] ? `SXTC_TICKS_HI : `SXTC_TICKS_LO);

   // A slave frame ends on its last rising clock edge and no falling edge follows it,
   // so the last bit retires once that rise has been seen instead of waiting for a fall.
   wire adv = sync_m & ~master ? (rose_r & (ck_fall | (bits_r == 4'd1)))
                               : (tick & (tcnt_r == per_bit - 7'd1));

   // ****************************************************************
   // Helpers
   // ****************************************************************
   function [3:0] frame_len;
      input s;
      input n;
      begin
         if (s)
            frame_len = n ? `SXTC_LEN_SYNC9 : `SXTC_LEN_SYNC8;
         else
            frame_len = n ? `SXTC_LEN_ASYNC9 : `SXTC_LEN_ASYNC8;
      end
   endfunction

   function [31:0] reg_read;
      input [`SXTC_AW-1:0] a;
      begin
         case (a)
            `SXTC_OFF_STATUS:
               reg_read = {24'h000000, stat_r[7:2], empty_r, stat_r[0]};
            `SXTC_OFF_BAUD:
               reg_read = {{(32-BAUD_W){1'b0}}, baud_r};
            `SXTC_OFF_PORT:
               reg_read = {31'h00000000, port_on_r};
            default:
               reg_read = 32'h00000000;
         endcase
      end
   endfunction

   // ****************************************************************
   // Baud generator
   // ****************************************************************
   sxtc_baud #(
      .WIDTH   (BAUD_W)
   ) u_baud (
      .hclk    (hclk),
      .hresetn (hresetn),
      .ce      (ce),
      .run     (go),
      .period  (baud_r),
      .tick    (tick)
   );

   // ****************************************************************
   // AHB-Lite slave, zero wait states, always OKAY
   // ****************************************************************
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         hrdata    <= 32'h00000000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         dp_wr_r   <= 1'b0;
         dp_addr_r <= {`SXTC_AW{1'b0}};
         stat_r    <= `SXTC_STAT_RST;
         port_on_r <= 1'b0;
         baud_r    <= `SXTC_BAUD_RST;
      end
      else if (ce)
      begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         dp_wr_r   <= ap & hwrite;
         dp_addr_r <= haddr[`SXTC_AW-1:0];
         // Read data is fetched in the address phase so it leaves a flop.
         hrdata    <= (ap & ~hwrite) ? reg_read(haddr[`SXTC_AW-1:0]) : 32'h00000000;
         if (dp_wr_r)
         begin
            case (dp_addr_r)
               `SXTC_OFF_STATUS:
                  stat_r <= hwdata[7:0] & `SXTC_STAT_WMASK;
               `SXTC_OFF_BAUD:
                  baud_r <= hwdata[BAUD_W-1:0];
               `SXTC_OFF_PORT:
                  port_on_r <= hwdata[`SXTC_B_PORT_ON];
               default:
                  port_on_r <= port_on_r;
            endcase
         end
      end
   end

   // ****************************************************************
   // Clock pin synchroniser
   // ****************************************************************
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ck_s1_r <= 1'b1;
         ck_s2_r <= 1'b1;
         ck_s3_r <= 1'b1;
      end
      else if (ce)
      begin
         ck_s1_r <= ck_i;
         ck_s2_r <= ck_s1_r;
         ck_s3_r <= ck_s2_r;
      end
   end

   // ****************************************************************
   // Transmit shifter
   // ****************************************************************
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         sh_r    <= 11'h7ff;
         bits_r  <= 4'd0;
         tcnt_r  <= 7'd0;
         empty_r <= 1'b1;
         rose_r  <= 1'b0;
      end
      else if (ce)
      begin
         if (!go)
         begin
            // Dropping the enable aborts a word in flight; it is not finished.
            sh_r    <= 11'h7ff;
            bits_r  <= 4'd0;
            tcnt_r  <= 7'd0;
            empty_r <= 1'b1;
            rose_r  <= 1'b0;
         end
         else if (load)
         begin
            if (sync_m)
               sh_r <= {2'b11, nine ? stat_r[`SXTC_B_NINTH] : 1'b1, hwdata[7:0]};
            else
               sh_r <= {1'b1, nine ? stat_r[`SXTC_B_NINTH] : 1'b1, hwdata[7:0], 1'b0};
            bits_r  <= frame_len(sync_m, nine);
            tcnt_r  <= 7'd0;
            empty_r <= 1'b0;
            rose_r  <= 1'b0;
         end
         else if (!empty_r)
         begin
            if (ck_rise)
               rose_r <= 1'b1;
            if (adv)
            begin
               sh_r   <= {1'b1, sh_r[10:1]};
               bits_r <= bits_r - 4'd1;
               tcnt_r <= 7'd0;
               rose_r <= 1'b0;
               if (bits_r == 4'd1)
                  empty_r <= 1'b1;
            end
            else if (tick)
               tcnt_r <= tcnt_r + 7'd1;
         end
      end
   end

   // ****************************************************************
   // Pin drivers
   // ****************************************************************
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ck_o   <= 1'b1;
         ck_oe  <= 1'b0;
         dat_o  <= 1'b1;
         dat_oe <= 1'b0;
      end
      else if (ce)
      begin
         // Master clock is low for the first half of each bit, data settles then.
         ck_o   <= empty_r | ~master | (tcnt_r >= `SXTC_SYNC_HALF);
         ck_oe  <= port_on_r & master;
         dat_o  <= empty_r ? 1'b1 : sh_r[0];
         // Synchronous mode is half duplex, so the data pin is released when idle.
         dat_oe <= port_on_r & (~sync_m | ~empty_r);
      end
   end
endmodule // sxtc_top

/* File: hdl/sxtc_consts.vh */
`ifndef SXTC_CONSTS_VH
`define SXTC_CONSTS_VH
// ****************************************************************
// Register map (byte addresses, low address bits only)
// ****************************************************************
`define SXTC_AW           8
`define SXTC_OFF_STATUS   8'h00
`define SXTC_OFF_DATA     8'h04
`define SXTC_OFF_BAUD     8'h08
`define SXTC_OFF_PORT     8'h0c
// ****************************************************************
// Fields of transmit_status_control, the port-on bit and register reset values
// ****************************************************************
`define SXTC_B_CLK_SRC    7
`define SXTC_B_NINE       6
`define SXTC_B_TRANSMIT_ENABLE_BIT       5
`define SXTC_B_SYNC       4
`define SXTC_B_HIRATE     2
`define SXTC_B_EMPTY      1
`define SXTC_B_NINTH      0
`define SXTC_B_PORT_ON    0
`define SXTC_STAT_RST     8'h00
`define SXTC_STAT_WMASK   8'hf5
`define SXTC_BAUD_RST     8'h00
// ****************************************************************
// Bit timing in baud generator ticks, frame lengths
// ****************************************************************
`define SXTC_TICKS_HI     7'd16
`define SXTC_TICKS_LO     7'd64
`define SXTC_TICKS_SYNC   7'd4
`define SXTC_SYNC_HALF    7'd2
`define SXTC_LEN_ASYNC8   4'd10
`define SXTC_LEN_ASYNC9   4'd11
`define SXTC_LEN_SYNC8    4'd8
`define SXTC_LEN_SYNC9    4'd9
`endif

/* File: hdl/sxtc_baud.v */
`timescale 1ns/1ps
// ****************************************************************
// Free-running reload timer, one tick every period+1 cycles
// ****************************************************************
module sxtc_baud #(
   parameter WIDTH = 8
) (
   input  wire             hclk,
   input  wire             hresetn,
   input  wire             ce,
   input  wire             run,
   input  wire [WIDTH-1:0] period,
   output reg              tick
);
   reg [WIDTH-1:0] cnt_r;

   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         cnt_r <= {WIDTH{1'b0}};
         tick  <= 1'b0;
      end
      else if (ce)
      begin
         if (!run)
         begin
            cnt_r <= period;
            tick  <= 1'b0;
         end
         else if (cnt_r == {WIDTH{1'b0}})
         begin
            cnt_r <= period;
            tick  <= 1'b1;
         end
         else
         begin
            cnt_r <= cnt_r - {{(WIDTH-1){1'b0}}, 1'b1};
            tick  <= 1'b0;
         end
      end
   end
endmodule // sxtc_baud

/* File: bench/sxtc_assertions.sv */
`timescale 1ns/1ps
// ********
// Checker fed by a shadow of the software writes.
// ********
module sxtc_assertions (
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic [31:0] hrdata,
   input wire logic        ck_oe,
   input wire logic        dat_o,
   input wire logic        dat_oe
);
   logic       ap_r, wr_r, po_r;
   logic [7:0] ad_r, st_r;
   wire        rd0 = ap_r && !wr_r && ad_r == 8'h00;
   wire        syn = st_r[4];
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ap_r <= 1'b0;
         wr_r <= 1'b0;
         ad_r <= 8'h00;
         st_r <= 8'h00;
         po_r <= 1'b0;
      end
      else
      begin
         ap_r <= hsel && htrans[1] && hready;
         wr_r <= hwrite;
         ad_r <= haddr[7:0];
         if (ap_r && wr_r && ad_r == 8'h00)
            st_r <= hwdata[7:0];
         if (ap_r && wr_r && ad_r == 8'h0c)
            po_r <= hwdata[0];
      end
   end
   a_status_readback: assert property (rd0 |-> (hrdata[7:0] & 8'hf5) == (st_r & 8'hf5))
      else $error("status readback differs from last write");
   a_gap_zero: assert property (rd0 |-> hrdata[3] == 1'b0)
      else $error("status bit 3 not zero");
   a_idle_empty: assert property ((!st_r[5])[*3] ##0 rd0 |-> hrdata[1])
      else $error("empty flag low while transmitter off");
   a_master_clk: assert property ((syn && st_r[7] && po_r)[*2] |-> ck_oe)
      else $error("clock pin not driven in master mode");
   a_slave_clk: assert property ((syn && !st_r[7])[*2] |-> !ck_oe)
      else $error("clock pin driven in slave mode");
   a_async_clk: assert property ((!syn)[*2] |-> !ck_oe)
      else $error("clock pin driven in asynchronous mode");
   a_tx_off: assert property ((!st_r[5])[*3] |-> dat_o)
      else $error("data pin active while transmitter off");
   a_async_pin: assert property ((!syn && po_r)[*2] |-> dat_oe)
      else $error("data pin not driven with port on");
   c_read: cover property (rd0);
   c_master: cover property (ck_oe);
   c_frame: cover property ($fell(dat_o));
endmodule // sxtc_assertions
bind sxtc_top sxtc_assertions chk_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata,
   .hready, .hrdata, .ck_oe, .dat_o, .dat_oe);

/* File: bench/sxtc_peer.sv */
`timescale 1ns/1ps
// ********
// Serial device on the clock and data pins.
// ********
module sxtc_peer (
   input  wire logic ck_pin,
   input  wire logic dat_pin,
   output logic      ck_drv,
   output logic      ck_en
);
   logic [8:0] word;
   int         cnt;
   realtime    t_last, t_gap;
   initial
   begin
      ck_drv = 1'b1;
      ck_en = 1'b0;
      t_last = 0.0;
   end
   // Data is taken on the rising clock edge, least significant bit first.
   always @(posedge ck_pin)
   begin
      word = {dat_pin, word[8:1]};
      cnt++;
      t_gap = $realtime - t_last;
      t_last = $realtime;
   end
   task clear();
      word = 9'h000;
      cnt = 0;
   endtask
   // The slave clock runs only inside a frame and rests high between frames.
   task gen(input int n);
      ck_en = 1'b1;
      // Edges sit off the system clock edges so the pin synchroniser never races them.
      #2;
      repeat (n)
      begin
         #40 ck_drv = 1'b0;
         #40 ck_drv = 1'b1;
      end
      ck_en = 1'b0;
   endtask
endmodule // sxtc_peer

/* File: bench/tb_serial_tx_status_control.sv */
`timescale 1ns/1ps
// ********
// Register and line tests.
// ********
module tb_serial_tx_status_control;
   logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, ck_o, ck_oe, dat_o, dat_oe, ck_drv, ck_en;
   logic [31:0] haddr, hwdata, hrdata, rdv;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   int          failures, tests_run;
   // Released pins are pulled high.
   wire         ck_pin = ck_oe ? ck_o : (ck_en ? ck_drv : 1'b1);
   wire         dat_pin = dat_oe ? dat_o : 1'b1;
   sxtc_top dut_u (.hclk, .hresetn, .ce(1'b1), .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready(hreadyout), .hrdata, .hreadyout, .hresp, .ck_i(ck_pin), .ck_o, .ck_oe, .dat_o, .dat_oe);
   sxtc_peer peer_u (.ck_pin, .dat_pin, .ck_drv, .ck_en);
   always #5 hclk = ~hclk;
   task check(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         failures++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'b10;
      hwrite <= w;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rdv = hrdata;
   endtask
   task rdc(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      check(rdv, exp);
   endtask
   task wait_empty();
      rdv = 32'h0;
      repeat (400) if (rdv[1] !== 1'b1) bus(1'b0, 8'h00, 32'h0);
      check({31'h0, rdv[1]}, 32'h1);
   endtask
   task async_chk(input logic [10:0] fr, input int nb, input int bt);
      int n;
      n = 0;
      while (dat_o !== 1'b0 && n < 200)
      begin
         @(posedge hclk);
         n++;
      end
      repeat (bt / 2) @(posedge hclk);
      for (int i = 0; i < nb; i++)
      begin
         check({31'h0, dat_o}, {31'h0, fr[i]});
         repeat (bt) @(posedge hclk);
      end
   endtask
   task finish_test();
      $display("Comparisons %0d, mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial
   begin
      #200000;
      failures++;
      finish_test();
   end
   initial
   begin
      {hclk, hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
      hsize = 3'b010;
      failures = 0;
      tests_run = 0;
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rdc(8'h00, 32'h02);
      rdc(8'h10, 32'h0);
      check({30'h0, hreadyout, hresp}, 32'h2);
      bus(1'b1, 8'h00, 32'hff);
      bus(1'b1, 8'h04, 32'h3c);
      rdc(8'h00, 32'hf7);
      check({31'h0, dat_oe}, 32'h0);
      bus(1'b1, 8'h0c, 32'h1);
      bus(1'b1, 8'h08, 32'h1);
      // The ninth bit is 0 here so that it cannot be mistaken for the stop bit.
      bus(1'b1, 8'h00, 32'he4);
      bus(1'b1, 8'h04, 32'h55);
      async_chk({1'b1, 1'b0, 8'h55, 1'b0}, 11, 32);
      bus(1'b1, 8'h08, 32'h0);
      bus(1'b1, 8'h00, 32'h21);
      bus(1'b1, 8'h04, 32'ha3);
      rdc(8'h00, 32'h21);
      async_chk({2'b11, 8'ha3, 1'b0}, 10, 64);
      wait_empty();
      bus(1'b1, 8'h04, 32'h00);
      repeat (100) @(posedge hclk);
      bus(1'b1, 8'h00, 32'h01);
      // The abort takes effect one clock after the enable is cleared.
      @(posedge hclk);
      rdc(8'h00, 32'h03);
      check({31'h0, dat_o}, 32'h1);
      peer_u.clear();
      bus(1'b1, 8'h00, 32'hb4);
      bus(1'b1, 8'h04, 32'h96);
      wait_empty();
      check({24'h0, peer_u.word[8:1]}, 32'h96);
      check(32'(peer_u.cnt), 32'd8);
      check(32'(int'(peer_u.t_gap)), 32'd40);
      bus(1'b1, 8'h00, 32'h71);
      peer_u.clear();
      bus(1'b1, 8'h04, 32'h4b);
      peer_u.gen(9);
      @(posedge hclk);
      wait_empty();
      check({23'h0, peer_u.word}, {23'h0, 1'b1, 8'h4b});
      finish_test();
   end
endmodule // tb_serial_tx_status_control
